//--- verilog/bfle_pkg.sv
package bfle_pkg;

	// Widths and register count
	localparam int DATA_W = 8;
	localparam int PC_W = 16;
	localparam int ADDR_W = 16;
	localparam int NREG = 32;
	localparam int AV_AW = 8;
	localparam int AV_DW = 32;

	// Register offsets, byte addresses
	localparam logic [AV_AW-1:0] OFF_CMD = 8'h00;
	localparam logic [AV_AW-1:0] OFF_STATUS = 8'h04;
	localparam logic [AV_AW-1:0] OFF_PC = 8'h08;
	localparam logic [AV_AW-1:0] OFF_COUNT = 8'h0C;
	localparam logic [AV_AW-1:0] OFF_GPR_BASE = 8'h80;

	// Status register fields
	localparam int STS_BUSY = 8;
	localparam int STS_BADOP = 9;

	// Flag register bit positions
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;

	// Reset values
	localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 16'h0000;
	localparam logic [DATA_W-1:0] GPR_RST = 8'h00;

	// Pointer pair selectors and low register index
	localparam logic [1:0] PTR_SEL_X = 2'h0;
	localparam logic [1:0] PTR_SEL_Y = 2'h1;
	localparam logic [1:0] PTR_SEL_Z = 2'h2;
	localparam logic [4:0] PTR_X_LO = 5'h1A;
	localparam logic [4:0] PTR_Y_LO = 5'h1C;
	localparam logic [4:0] PTR_Z_LO = 5'h1E;

	// Operation codes
	localparam logic [4:0] OP_NOP = 5'h00;
	localparam logic [4:0] OP_BRANCH_IRQ_ON = 5'h01;
	localparam logic [4:0] OP_BRANCH_IRQ_OFF = 5'h02;
	localparam logic [4:0] OP_SET_IO_BIT = 5'h03;
	localparam logic [4:0] OP_CLEAR_IO_BIT = 5'h04;
	localparam logic [4:0] OP_LOGICAL_LEFT_SHIFT = 5'h05;
	localparam logic [4:0] OP_LOGICAL_RIGHT_SHIFT = 5'h06;
	localparam logic [4:0] OP_LEFT_CARRY_ROTATE = 5'h07;
	localparam logic [4:0] OP_RIGHT_CARRY_ROTATE = 5'h08;
	localparam logic [4:0] OP_SIGN_KEEPING_RIGHT_SHIFT = 5'h09;
	localparam logic [4:0] OP_NIBBLE_EXCHANGE = 5'h0A;
	localparam logic [4:0] OP_GENERIC_FLAG_SET = 5'h0B;
	localparam logic [4:0] OP_GENERIC_FLAG_CLEAR = 5'h0C;
	localparam logic [4:0] OP_BIT_TO_TRANSFER_FLAG = 5'h0D;
	localparam logic [4:0] OP_TRANSFER_FLAG_TO_BIT = 5'h0E;
	localparam logic [4:0] OP_REG_COPY = 5'h0F;
	localparam logic [4:0] OP_PAIR_COPY = 5'h10;
	localparam logic [4:0] OP_IMMEDIATE_FETCH = 5'h11;
	localparam logic [4:0] OP_INDIRECT_FETCH = 5'h12;
	localparam logic [4:0] OP_INDIRECT_FETCH_INC = 5'h13;
	localparam logic [4:0] OP_INDIRECT_FETCH_DEC = 5'h14;
	localparam logic [4:0] OP_DISPLACED_FETCH = 5'h15;

	// Command word as written to the command register
	typedef struct packed {
		logic spare_hi;
		logic [1:0] ptr;
		logic [2:0] bitn;
		logic [4:0] rr;
		logic [4:0] rd;
		logic [2:0] spare_lo;
		logic [4:0] op;
		logic [7:0] imm;
	} bfle_cmd_t;

	// Data memory and I/O request
	typedef struct packed {
		logic req;
		logic we;
		logic io;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bfle_mem_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOAD,
		ST_IO_RMW,
		ST_WAIT
	} bfle_state_t;

endpackage

//--- verilog/bfle_shift.sv
`timescale 1ns/1ns
module bfle_shift (
	// Operation
	input wire logic [4:0] op,
	input wire logic [bfle_pkg::DATA_W-1:0] din,
	input wire logic cin,
	// Result
	output logic [bfle_pkg::DATA_W-1:0] dout,
	output logic cout
);
	import bfle_pkg::*;

	always_comb begin
		dout = din;
		cout = cin;
		case (op)
			OP_LOGICAL_LEFT_SHIFT: begin
				dout = {din[6:0], 1'b0};
				cout = din[7];
			end
			OP_LEFT_CARRY_ROTATE: begin
				dout = {din[6:0], cin};
				cout = din[7];
			end
			OP_LOGICAL_RIGHT_SHIFT: begin
				dout = {1'b0, din[7:1]};
				cout = din[0];
			end
			OP_RIGHT_CARRY_ROTATE: begin
				dout = {cin, din[7:1]};
				cout = din[0];
			end
			OP_SIGN_KEEPING_RIGHT_SHIFT: begin
				dout = {din[7], din[7:1]};
				cout = din[0];
			end
			default: begin
				dout = din;
				cout = cin;
			end
		endcase
	end

endmodule

//--- verilog/bfle_core.sv
`timescale 1ns/1ns
module bfle_core (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [bfle_pkg::AV_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [bfle_pkg::AV_DW-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [bfle_pkg::AV_DW-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Data memory and I/O space
	output bfle_pkg::bfle_mem_t mem_o,
	input wire logic [bfle_pkg::DATA_W-1:0] mem_rdata
);
	import bfle_pkg::*;

	logic [DATA_W-1:0] gpr_q [NREG];
	logic [DATA_W-1:0] flags_q;
	logic [DATA_W-1:0] flags_d;
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] pc_d;
	logic [31:0] count_q;
	logic badop_q;
	logic badop_set;
	bfle_cmd_t cmd_q;
	bfle_cmd_t cmd_w;
	bfle_state_t state_q;
	bfle_state_t state_d;
	bfle_mem_t mem_q;
	bfle_mem_t mem_d;
	logic waitreq_q;
	logic [AV_DW-1:0] rdata_q;
	logic [AV_DW-1:0] rdata_d;
	logic acc;
	logic wr;
	logic cmd_go;
	logic in_gpr;
	logic [4:0] gpr_sel;
	logic wa_en;
	logic [4:0] wa_idx;
	logic [DATA_W-1:0] wa_dat;
	logic wb_en;
	logic [4:0] wb_idx;
	logic [DATA_W-1:0] wb_dat;
	logic [DATA_W-1:0] src_d;
	logic [DATA_W-1:0] sh_res;
	logic sh_c;
	logic [4:0] ptr_lo;
	logic [ADDR_W-1:0] ptr_val;
	logic [ADDR_W-1:0] ptr_inc;
	logic [ADDR_W-1:0] ptr_dec;
	logic [PC_W-1:0] k_ext;
	logic [DATA_W-1:0] io_mod;

	// Bus request decode; only taken while the engine is idle
	assign acc = (avs_read | avs_write) & waitreq_q & (state_q == ST_IDLE);
	assign wr = acc & avs_write;
	assign cmd_w = bfle_cmd_t'(avs_writedata);
	assign cmd_go = wr & (avs_address == OFF_CMD) & (&avs_byteenable);
	assign in_gpr = (avs_address & OFF_GPR_BASE) == OFF_GPR_BASE;
	assign gpr_sel = avs_address[6:2];

	// Operand helpers
	assign src_d = gpr_q[cmd_w.rd];
	assign k_ext = {{(PC_W - 7){cmd_w.imm[6]}}, cmd_w.imm[6:0]};
	assign ptr_val = {gpr_q[ptr_lo + 5'h01], gpr_q[ptr_lo]};
	assign ptr_inc = ptr_val + 16'h0001;
	assign ptr_dec = ptr_val - 16'h0001;

	always_comb begin
		case (cmd_w.ptr)
			PTR_SEL_X: ptr_lo = PTR_X_LO;
			PTR_SEL_Y: ptr_lo = PTR_Y_LO;
			default: ptr_lo = PTR_Z_LO;
		endcase
	end

	// Read-modify-write value for I/O bit ops
	always_comb begin
		io_mod = mem_rdata;
		io_mod[cmd_q.bitn] = (cmd_q.op == OP_SET_IO_BIT);
	end

	bfle_shift u_shift (
		.op(cmd_w.op),
		.din(src_d),
		.cin(flags_q[FLG_C]),
		.dout(sh_res),
		.cout(sh_c)
	);

	// Instruction execution and register writes
	always_comb begin
		wa_en = 1'b0;
		wa_idx = cmd_w.rd;
		wa_dat = GPR_RST;
		wb_en = 1'b0;
		wb_idx = cmd_w.rd;
		wb_dat = GPR_RST;
		flags_d = flags_q;
		pc_d = pc_q;
		state_d = state_q;
		mem_d = '0;
		badop_set = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (cmd_go) begin
					pc_d = pc_q + 16'h0001;
					case (cmd_w.op)
						OP_NOP: pc_d = pc_q + 16'h0001;
						OP_BRANCH_IRQ_ON: begin
							if (flags_q[FLG_I]) begin
								pc_d = pc_q + 16'h0001 + k_ext;
								state_d = ST_WAIT;
							end
						end
						OP_BRANCH_IRQ_OFF: begin
							if (!flags_q[FLG_I]) begin
								pc_d = pc_q + 16'h0001 + k_ext;
								state_d = ST_WAIT;
							end
						end
						OP_SET_IO_BIT, OP_CLEAR_IO_BIT: begin
							mem_d.req = 1'b1;
							mem_d.io = 1'b1;
							mem_d.addr = {11'h000, cmd_w.imm[4:0]};
							state_d = ST_IO_RMW;
						end
						OP_LOGICAL_LEFT_SHIFT, OP_LEFT_CARRY_ROTATE, OP_LOGICAL_RIGHT_SHIFT,
						OP_RIGHT_CARRY_ROTATE, OP_SIGN_KEEPING_RIGHT_SHIFT: begin
							wa_en = 1'b1;
							wa_dat = sh_res;
							flags_d[FLG_Z] = (sh_res == 8'h00);
							flags_d[FLG_C] = sh_c;
							flags_d[FLG_N] = sh_res[7];
							flags_d[FLG_V] = sh_res[7] ^ sh_c;
						end
						OP_NIBBLE_EXCHANGE: begin
							wa_en = 1'b1;
							wa_dat = {src_d[3:0], src_d[7:4]};
						end
						OP_GENERIC_FLAG_SET: begin
							flags_d[cmd_w.bitn] = 1'b1;
						end
						OP_GENERIC_FLAG_CLEAR: begin
							flags_d[cmd_w.bitn] = 1'b0;
						end
						OP_BIT_TO_TRANSFER_FLAG: begin
							flags_d[FLG_T] = gpr_q[cmd_w.rr][cmd_w.bitn];
						end
						OP_TRANSFER_FLAG_TO_BIT: begin
							wa_en = 1'b1;
							wa_dat = src_d;
							wa_dat[cmd_w.bitn] = flags_q[FLG_T];
						end
						OP_REG_COPY: begin
							wa_en = 1'b1;
							wa_dat = gpr_q[cmd_w.rr];
						end
						OP_PAIR_COPY: begin
							wa_en = 1'b1;
							wa_idx = {cmd_w.rd[4:1], 1'b0};
							wa_dat = gpr_q[{cmd_w.rr[4:1], 1'b0}];
							wb_en = 1'b1;
							wb_idx = {cmd_w.rd[4:1], 1'b1};
							wb_dat = gpr_q[{cmd_w.rr[4:1], 1'b1}];
						end
						OP_IMMEDIATE_FETCH: begin
							wa_en = 1'b1;
							wa_dat = cmd_w.imm;
						end
						OP_INDIRECT_FETCH: begin
							mem_d.req = 1'b1;
							mem_d.addr = ptr_val;
							state_d = ST_LOAD;
						end
						OP_INDIRECT_FETCH_INC: begin
							mem_d.req = 1'b1;
							mem_d.addr = ptr_val;
							wa_en = 1'b1;
							wa_idx = ptr_lo;
							wa_dat = ptr_inc[7:0];
							wb_en = 1'b1;
							wb_idx = ptr_lo + 5'h01;
							wb_dat = ptr_inc[15:8];
							state_d = ST_LOAD;
						end
						OP_INDIRECT_FETCH_DEC: begin
							mem_d.req = 1'b1;
							mem_d.addr = ptr_dec;
							wa_en = 1'b1;
							wa_idx = ptr_lo;
							wa_dat = ptr_dec[7:0];
							wb_en = 1'b1;
							wb_idx = ptr_lo + 5'h01;
							wb_dat = ptr_dec[15:8];
							state_d = ST_LOAD;
						end
						OP_DISPLACED_FETCH: begin
							mem_d.req = 1'b1;
							mem_d.addr = ptr_val + {10'h000, cmd_w.imm[5:0]};
							state_d = ST_LOAD;
						end
						default: badop_set = 1'b1;
					endcase
				end else if (wr & in_gpr & avs_byteenable[0]) begin
					wa_en = 1'b1;
					wa_idx = gpr_sel;
					wa_dat = avs_writedata[7:0];
				end else if (wr & (avs_address == OFF_STATUS) & avs_byteenable[0]) begin
					flags_d = avs_writedata[7:0];
				end else if (wr & (avs_address == OFF_PC)) begin
					if (avs_byteenable[0]) begin
						pc_d[7:0] = avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						pc_d[15:8] = avs_writedata[15:8];
					end
				end
			end
			ST_LOAD: begin
				wa_en = 1'b1;
				wa_idx = cmd_q.rd;
				wa_dat = mem_rdata;
				state_d = ST_IDLE;
			end
			ST_IO_RMW: begin
				mem_d.req = 1'b1;
				mem_d.we = 1'b1;
				mem_d.io = 1'b1;
				mem_d.addr = mem_q.addr;
				mem_d.wdata = io_mod;
				state_d = ST_WAIT;
			end
			ST_WAIT: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// Register file
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NREG; i++) begin
				gpr_q[i] <= GPR_RST;
			end
		end else begin
			if (wa_en) begin
				gpr_q[wa_idx] <= wa_dat;
			end
			if (wb_en) begin
				gpr_q[wb_idx] <= wb_dat;
			end
		end
	end

	// Flags and program counter
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= FLAGS_RST;
			pc_q <= PC_RST;
		end else begin
			flags_q <= flags_d;
			pc_q <= pc_d;
		end
	end

	// Sequencer and latched command
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			cmd_q <= '0;
		end else begin
			state_q <= state_d;
			if (cmd_go) begin
				cmd_q <= cmd_w;
			end
		end
	end

	// Retired command count and undefined opcode flag, set wins over clear
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= 32'h0000_0000;
			badop_q <= 1'b0;
		end else begin
			if (cmd_go) begin
				count_q <= count_q + 32'h0000_0001;
			end else if (wr & (avs_address == OFF_COUNT)) begin
				count_q <= 32'h0000_0000;
			end
			if (badop_set) begin
				badop_q <= 1'b1;
			end else if (wr & (avs_address == OFF_STATUS) & avs_byteenable[1] & avs_writedata[STS_BADOP]) begin
				badop_q <= 1'b0;
			end
		end
	end

	// Memory request port
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mem_q <= '0;
		end else begin
			mem_q <= mem_d;
		end
	end

	// Read data mux
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (in_gpr) begin
			rdata_d[7:0] = gpr_q[gpr_sel];
		end else begin
			case (avs_address)
				OFF_CMD: rdata_d = cmd_q;
				OFF_STATUS: begin
					rdata_d[7:0] = flags_q;
					rdata_d[STS_BUSY] = (state_q != ST_IDLE);
					rdata_d[STS_BADOP] = badop_q;
				end
				OFF_PC: rdata_d[15:0] = pc_q;
				OFF_COUNT: rdata_d = count_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Bus answer, one wait cycle per access while the engine is idle; more while it is busy
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			waitreq_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (acc) begin
				waitreq_q <= 1'b0;
				rdata_q <= rdata_d;
			end else begin
				waitreq_q <= 1'b1;
			end
		end
	end

	assign avs_waitrequest = waitreq_q;
	assign avs_readdata = rdata_q;
	assign mem_o = mem_q;

endmodule

//--- dv/bfle_mem_model.sv
`timescale 1ns/1ns
module bfle_mem_model (
	// Clock
	input wire logic mclk,
	// Request and answer
	input bfle_pkg::bfle_mem_t mem_o,
	output logic [bfle_pkg::DATA_W-1:0] mem_rdata
);
	import bfle_pkg::*;
	logic [7:0] io_q [32];
	logic [7:0] junk_q = 8'h00;
	function automatic logic [7:0] fill(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	initial foreach (io_q[i]) io_q[i] = fill(16'(i));
	// Idle data bus keeps changing
	always @(posedge mclk) begin
		junk_q <= junk_q + 8'h3B;
		if (mem_o.req && mem_o.we && mem_o.io) begin
			io_q[mem_o.addr[4:0]] <= mem_o.wdata;
		end
	end
	assign mem_rdata = (!mem_o.req || mem_o.we) ? ~junk_q : mem_o.io ? io_q[mem_o.addr[4:0]] : fill(mem_o.addr);
endmodule

//--- dv/bfle_core_assertions.sv
`timescale 1ns/1ns
module bfle_core_assertions (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Memory
	input bfle_pkg::bfle_mem_t mem_o,
	input wire logic [7:0] mem_rdata
);
	import bfle_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_answer_bounded: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:4] !avs_waitrequest)
		else $error("bus answer late");
	a_ack_has_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without request");
	a_mem_rest_zero: assert property (!mem_o.req |-> mem_o == '0)
		else $error("memory fields not cleared");
	a_io_read_write: assert property (
		mem_o.req && mem_o.io && !mem_o.we |=> mem_o.req && mem_o.io && mem_o.we && $stable(mem_o.addr))
		else $error("io write not after read");
	a_io_one_bit: assert property (
		mem_o.req && mem_o.we |-> $countones(mem_o.wdata ^ $past(mem_rdata)) <= 1)
		else $error("io write alters other bits");
	a_load_one_read: assert property (mem_o.req && !mem_o.io |-> !mem_o.we ##1 !mem_o.req)
		else $error("load not a single read");
	a_cmd_causes_mem: assert property ($rose(mem_o.req) |-> $past(avs_write) && $past(avs_address) == OFF_CMD)
		else $error("memory access without command");
endmodule
bind bfle_core bfle_core_assertions u_chk (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_o(mem_o), .mem_rdata(mem_rdata));

//--- dv/testbench.sv
`timescale 1ns/1ns
module testbench;
	import bfle_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	bfle_mem_t mem_o;
	logic [7:0] mem_rdata;
	logic [7:0] io_exp [32];
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	bfle_core dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_o(mem_o), .mem_rdata(mem_rdata));
	bfle_mem_model u_mem (.mclk(mclk), .mem_o(mem_o), .mem_rdata(mem_rdata));
	initial forever #4 mclk = ~mclk;
	task automatic stop_test;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			stop_test;
		end
	end
	function automatic logic [7:0] mem_at(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	function automatic logic [15:0] shift_exp(input logic [4:0] op, input logic [7:0] v, input logic [7:0] f);
		logic [7:0] r;
		logic c;
		c = (op == OP_LOGICAL_LEFT_SHIFT || op == OP_LEFT_CARRY_ROTATE) ? v[7] : v[0];
		case (op)
			OP_LOGICAL_LEFT_SHIFT: r = {v[6:0], 1'b0};
			OP_LOGICAL_RIGHT_SHIFT: r = {1'b0, v[7:1]};
			OP_LEFT_CARRY_ROTATE: r = {v[6:0], f[FLG_C]};
			OP_RIGHT_CARRY_ROTATE: r = {f[FLG_C], v[7:1]};
			OP_SIGN_KEEPING_RIGHT_SHIFT: r = {v[7], v[7:1]};
			default: return {f, v[3:0], v[7:4]};
		endcase
		f[FLG_C] = c;
		f[FLG_Z] = r == 8'h00;
		f[FLG_N] = r[7];
		f[FLG_V] = r[7] ^ c;
		return {f, r};
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0000_0000, q);
	endtask
	task automatic wreg(input logic [4:0] n, input logic [7:0] v);
		wr(OFF_GPR_BASE + {1'b0, n, 2'b00}, {24'h00_0000, v});
	endtask
	task automatic chk_reg(input logic [4:0] n, input logic [7:0] e);
		logic [31:0] q;
		rd(OFF_GPR_BASE + {1'b0, n, 2'b00}, q);
		check(q, {24'h00_0000, e});
	endtask
	task automatic chk_flags(input logic [7:0] e);
		logic [31:0] q;
		rd(OFF_STATUS, q);
		check(q & 32'h0000_00FF, {24'h00_0000, e});
	endtask
	task automatic cmd(input logic [4:0] op, input logic [4:0] d, input logic [4:0] r, input logic [2:0] b,
		input logic [1:0] p, input logic [7:0] imm);
		wr(OFF_CMD, bfle_cmd_t'{1'b0, p, b, r, d, 3'h0, op, imm});
	endtask
	initial begin
		logic [31:0] q;
		logic [15:0] p;
		logic [15:0] a;
		logic [7:0] v;
		logic [7:0] f;
		logic [7:0] e;
		logic [4:0] n;
		logic [4:0] op;
		logic [4:0] lo;
		logic [2:0] b;
		q = $urandom(10116);
		foreach (io_exp[i]) io_exp[i] = mem_at(16'(i));
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		chk_flags(FLAGS_RST);
		rd(OFF_PC, q);
		check(q, {16'h0000, PC_RST});
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, q);
		check(q, 32'h0000_0000);
		for (int i = 0; i < 48; i++) begin
			op = OP_LOGICAL_LEFT_SHIFT + 5'(i % 6);
			n = 5'($urandom % 26);
			v = i < 6 ? 8'h81 : i < 12 ? 8'h00 : 8'($urandom);
			f = 8'($urandom);
			wreg(n, v);
			wr(OFF_STATUS, {24'h00_0000, f});
			cmd(op, n, 5'h00, 3'h0, 2'h0, 8'h00);
			{e, v} = shift_exp(op, v, f);
			chk_reg(n, v);
			chk_flags(e);
		end
		for (int s = 0; s < 16; s++) begin
			f = 8'($urandom);
			wr(OFF_STATUS, {24'h00_0000, f});
			cmd(s < 8 ? OP_GENERIC_FLAG_SET : OP_GENERIC_FLAG_CLEAR, 5'h00, 5'h00, 3'(s), 2'h0, 8'h00);
			f[s % 8] = s < 8;
			chk_flags(f);
		end
		for (int i = 0; i < 16; i++) begin
			b = 3'($urandom);
			v = 8'($urandom);
			n = 5'(1 + $urandom % 20);
			wreg(n, v);
			wreg(5'h00, ~v);
			cmd(OP_BIT_TO_TRANSFER_FLAG, 5'h00, n, b, 2'h0, 8'h00);
			f[FLG_T] = v[b];
			chk_flags(f);
			cmd(OP_TRANSFER_FLAG_TO_BIT, 5'h00, 5'h00, b, 2'h0, 8'h00);
			e = ~v;
			e[b] = v[b];
			chk_reg(5'h00, e);
		end
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			e = 8'($urandom);
			wreg(5'h02, v);
			wreg(5'h03, e);
			cmd(OP_REG_COPY, 5'h05, 5'h02, 3'h0, 2'h0, 8'h00);
			chk_reg(5'h05, v);
			cmd(OP_PAIR_COPY, 5'h08, 5'h02, 3'h0, 2'h0, 8'h00);
			chk_reg(5'h08, v);
			chk_reg(5'h09, e);
			cmd(OP_IMMEDIATE_FETCH, 5'h0C, 5'h00, 3'h0, 2'h0, ~e);
			chk_reg(5'h0C, ~e);
		end
		chk_flags(f);
		for (int i = 0; i < 16; i++) begin
			f = 8'($urandom);
			f[FLG_I] = i % 4 < 2;
			p = 16'($urandom);
			v = 8'($urandom);
			wr(OFF_STATUS, {24'h00_0000, f});
			wr(OFF_PC, {16'h0000, p});
			cmd(i % 2 ? OP_BRANCH_IRQ_OFF : OP_BRANCH_IRQ_ON, 5'h00, 5'h00, 3'h0, 2'h0, v);
			a = p + 16'h0001;
			if (f[FLG_I] != i % 2)
				a = a + {{9{v[6]}}, v[6:0]};
			rd(OFF_PC, q);
			check(q, {16'h0000, a});
			chk_flags(f);
		end
		for (int i = 0; i < 16; i++) begin
			lo = i % 3 == 2 ? PTR_Z_LO : i % 3 ? PTR_Y_LO : PTR_X_LO;
			op = OP_INDIRECT_FETCH + 5'(i / 2 % 4);
			p = i == 2 ? 16'hFFFF : i == 4 ? 16'h0000 : 16'($urandom);
			v = 8'($urandom % 64);
			n = 5'($urandom % 20);
			wreg(lo, p[7:0]);
			wreg(lo + 5'h01, p[15:8]);
			cmd(op, n, 5'h00, 3'h0, i % 3 == 2 ? PTR_SEL_Z : i % 3 ? PTR_SEL_Y : PTR_SEL_X, v);
			a = op == OP_INDIRECT_FETCH_DEC ? p - 16'h0001 : op == OP_DISPLACED_FETCH ? p + {10'h000, v[5:0]} : p;
			p = op == OP_INDIRECT_FETCH_INC ? p + 16'h0001 : op == OP_INDIRECT_FETCH_DEC ? a : p;
			chk_reg(n, mem_at(a));
			chk_reg(lo, p[7:0]);
			chk_reg(lo + 5'h01, p[15:8]);
		end
		chk_flags(f);
		for (int i = 0; i < 16; i++) begin
			n = i < 4 ? 5'h05 : 5'($urandom);
			b = 3'($urandom);
			cmd(i % 2 ? OP_CLEAR_IO_BIT : OP_SET_IO_BIT, 5'h00, 5'h00, b, 2'h0, {3'h0, n});
			io_exp[n][b] = i % 2 == 0;
			chk_flags(f);
			check({24'h00_0000, u_mem.io_q[n]}, {24'h00_0000, io_exp[n]});
		end
		// Partial command write, no-op, undefined op, count and readback
		p = 16'($urandom);
		v = 8'($urandom);
		wr(OFF_PC, {16'h0000, p});
		wr(OFF_COUNT, 32'h0000_0000);
		wreg(5'h01, v);
		avs_byteenable <= 4'h7;
		cmd(OP_IMMEDIATE_FETCH, 5'h01, 5'h00, 3'h0, 2'h0, ~v);
		avs_byteenable <= 4'hF;
		cmd(OP_NOP, 5'h00, 5'h00, 3'h0, 2'h0, 8'h00);
		cmd(5'h1F, 5'h00, 5'h00, 3'h0, 2'h0, v);
		chk_reg(5'h01, v);
		rd(OFF_STATUS, q);
		check(q, {22'h00_0000, 2'b10, f});
		rd(OFF_PC, q);
		check(q, {16'h0000, p + 16'h0002});
		rd(OFF_COUNT, q);
		check(q, 32'h0000_0002);
		rd(OFF_CMD, q);
		check(q, {19'h0_0000, 5'h1F, v});
		wr(OFF_STATUS, {22'h00_0000, 2'b10, f});
		rd(OFF_STATUS, q);
		check(q, {24'h00_0000, f});
		stop_test;
	end
endmodule
